// file: itc_integration_time_controller.sv
/*
  Integration time controller: selection capture, 1 ms tick, integration counter,
  trigger to the timing generator, AXI4-Lite register slave.
  Assumes all inputs synchronous to aclk and a host that resets after changing selection.
*/
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`include "itc_cfg.svh"

module itc_integration_time_controller #(
  parameter int TICK_CYCLES = `ITC_TICK_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [4:0]  integration_select_bits,
  input  wire logic        binning_select_switch,
  input  wire logic        frame_readout_done,
  output logic             integration_done_trigger,
  output logic [10:0]      shutter_start_line,
  output logic             shutter_line_load,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  // ========================================================================
  // Setting lookup
  function automatic itc_pkg::itc_setting_t itc_lookup(input logic [4:0] sel,
                                                       input logic       half);
    itc_pkg::itc_setting_t s;
    logic [10:0]           line;
    s.shutter_line = `ITC_NO_SHUTTER;
    s.ms_count     = 13'h0000;
    line = `ITC_FRAME_LINES - 11'(sel) * (`ITC_FRAME_LINES >> `ITC_FRACTION_LOG2);
    if (sel == 5'h00) begin
      s.ms_count = 13'h0000;
    end else if (sel <= `ITC_SHORT_SEL_MAX) begin
      s.shutter_line = half ? (line >> 1) : line;
    end else if (sel <= `ITC_TABLE_SEL_MAX) begin
      unique case (sel[2:0])
        3'h0: s.ms_count = `ITC_MS_SEL8;
        3'h1: s.ms_count = `ITC_MS_SEL9;
        3'h2: s.ms_count = `ITC_MS_SEL10;
        3'h3: s.ms_count = `ITC_MS_SEL11;
        3'h4: s.ms_count = `ITC_MS_SEL12;
        3'h5: s.ms_count = `ITC_MS_SEL13;
        3'h6: s.ms_count = `ITC_MS_SEL14;
        3'h7: s.ms_count = `ITC_MS_SEL15;
      endcase
    end else if (sel <= `ITC_HUNDRED_SEL_MAX) begin
      s.ms_count = 13'(13'(sel - `ITC_HUNDRED_BASE) * `ITC_MS_HUNDRED);
    end else begin
      s.ms_count = 13'(13'(sel - `ITC_THOUSAND_BASE) * `ITC_MS_THOUSAND);
    end
    return s;
  endfunction : itc_lookup

  // ========================================================================
  // Selection capture after reset
  logic                  captured_r;
  logic                  captured_q_r;
  logic [4:0]            sel_r;
  logic                  binning_r;
  logic                  dual_r;
  logic                  reload_r;
  itc_pkg::itc_setting_t setting_r;
  itc_pkg::itc_setting_t setting_nxt;

  assign setting_nxt = itc_lookup(sel_r, binning_r | dual_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      captured_r <= 1'b0;
      sel_r      <= 5'h00;
      binning_r  <= 1'b0;
    end else if (clk_en && !captured_r) begin
      captured_r <= 1'b1;
      sel_r      <= integration_select_bits;
      binning_r  <= binning_select_switch;
    end
  end

  // Setting follows the captured selection; load strobe in the same cycle as the new line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      captured_q_r       <= 1'b0;
      setting_r          <= '{`ITC_NO_SHUTTER, 13'h0000};
      shutter_start_line <= `ITC_NO_SHUTTER;
      shutter_line_load  <= 1'b0;
    end else if (clk_en) begin
      captured_q_r       <= captured_r;
      setting_r          <= setting_nxt;
      shutter_start_line <= setting_nxt.shutter_line;
      shutter_line_load  <= (captured_r && !captured_q_r) || reload_r;
    end
  end

  // ========================================================================
  // 1 ms tick
  logic [$clog2(TICK_CYCLES)-1:0] presc_r;
  logic                           tick_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_r <= '0;
      tick_r  <= 1'b0;
    end else if (clk_en) begin
      tick_r <= (presc_r == $bits(presc_r)'(TICK_CYCLES - 1));
      if (presc_r == $bits(presc_r)'(TICK_CYCLES - 1)) begin
        presc_r <= '0;
      end else begin
        presc_r <= presc_r + 1'b1;
      end
    end
  end

  // ========================================================================
  // Integration counter and trigger
  itc_pkg::itc_phase_t phase_r;
  logic [12:0]         count_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_r                  <= itc_pkg::ITC_IDLE;
      count_r                  <= 13'h0000;
      integration_done_trigger <= 1'b0;
    end else if (clk_en) begin
      integration_done_trigger <= 1'b0;
      if (frame_readout_done) begin
        phase_r <= itc_pkg::ITC_COUNT;
        count_r <= 13'h0000;
      end else begin
        unique case (phase_r)
          itc_pkg::ITC_IDLE: count_r <= count_r;
          itc_pkg::ITC_COUNT: begin
            if (tick_r) begin
              if (count_r == setting_r.ms_count) begin
                integration_done_trigger <= 1'b1;
                phase_r                  <= itc_pkg::ITC_IDLE;
              end else begin
                count_r <= count_r + 13'h0001;
              end
            end
          end
        endcase
      end
    end
  end

  // ========================================================================
  // AXI4-Lite slave
  logic        aw_full_r;
  logic        w_full_r;
  logic [3:0]  waddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        do_write;
  logic [31:0] rdata_nxt;
  logic        rmapped;

  assign do_write = aw_full_r && w_full_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r     <= 1'b0;
      s_axi_awready <= 1'b0;
      waddr_r       <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r     <= 1'b1;
        s_axi_awready <= 1'b0;
        waddr_r       <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full_r     <= 1'b0;
        s_axi_awready <= 1'b1;
      end else if (!aw_full_r) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r     <= 1'b0;
      s_axi_wready <= 1'b0;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r     <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
      end else if (do_write) begin
        w_full_r     <= 1'b0;
        s_axi_wready <= 1'b1;
      end else if (!w_full_r) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control register write and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dual_r       <= `ITC_CTRL_RESET;
      reload_r     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ITC_RESP_OKAY;
    end else if (clk_en) begin
      reload_r <= 1'b0;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `ITC_RESP_OKAY;
        if (waddr_r[3:2] == 2'(`ITC_OFS_CTRL >> 2) && wstrb_r[0]) begin
          dual_r   <= wdata_r[`ITC_CTRL_DUAL_BIT];
          reload_r <= 1'b1;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rmapped   = 1'b1;
    unique case (s_axi_araddr[3:2])
      2'(`ITC_OFS_CTRL >> 2):    rdata_nxt = {31'h0000_0000, dual_r};
      2'(`ITC_OFS_STATUS >> 2):  rdata_nxt = {24'h00_0000, binning_r | dual_r,
                                              phase_r == itc_pkg::ITC_COUNT,
                                              binning_r, sel_r};
      2'(`ITC_OFS_SHUTTER >> 2): rdata_nxt = {21'h00_0000, setting_r.shutter_line};
      2'(`ITC_OFS_MSCOUNT >> 2): rdata_nxt = {3'h0, count_r, 3'h0, setting_r.ms_count};
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ITC_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdata_nxt;
        s_axi_rresp   <= rmapped ? `ITC_RESP_OKAY : `ITC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Checks
  sequence s_count_done;
    clk_en && phase_r == itc_pkg::ITC_COUNT && tick_r && !frame_readout_done &&
      count_r == setting_r.ms_count;
  endsequence

  sequence s_readout;
    clk_en && frame_readout_done;
  endsequence

  a_trig_on_done: assert property (@(posedge aclk) disable iff (!aresetn)
    s_count_done |=> integration_done_trigger)
    else $error("trigger missing after count reached");

  a_trig_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(integration_done_trigger) |-> $past(tick_r) &&
      $past(count_r) == $past(setting_r.ms_count))
    else $error("trigger without tick at target count");

  a_trig_single: assert property (@(posedge aclk) disable iff (!aresetn)
    integration_done_trigger && clk_en |=> !integration_done_trigger &&
      (phase_r == itc_pkg::ITC_IDLE || $past(frame_readout_done)))
    else $error("trigger repeated within frame");

  a_readout_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    s_readout |=> count_r == 13'h0000 && phase_r == itc_pkg::ITC_COUNT)
    else $error("readout did not restart counter");

  a_count_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && !tick_r && !frame_readout_done |=> $stable(count_r))
    else $error("counter moved without tick");

  a_zero_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    captured_r && $past(captured_r) && (sel_r == 5'h00 || sel_r > `ITC_SHORT_SEL_MAX)
      |-> setting_r.shutter_line == `ITC_NO_SHUTTER)
    else $error("shutter not suppressed");

  a_short_line: assert property (@(posedge aclk) disable iff (!aresetn)
    captured_r && sel_r != 5'h00 && sel_r <= `ITC_SHORT_SEL_MAX && setting_r == setting_nxt
      |-> setting_r.ms_count == 13'h0000 &&
          setting_r.shutter_line == ((binning_r | dual_r) ?
            11'(66 * (8 - sel_r)) : 11'(132 * (8 - sel_r))))
    else $error("wrong short shutter line");

  a_ms_top: assert property (@(posedge aclk) disable iff (!aresetn)
    setting_r == setting_nxt && sel_r == 5'h1F |-> setting_r.ms_count == 13'(8000))
    else $error("wrong count for top selection");

  a_sel_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && $past(captured_r) |-> $stable(sel_r) && $stable(binning_r))
    else $error("selection resampled outside reset");

  a_load_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(captured_r) && clk_en |=> shutter_line_load)
    else $error("no shutter load after reset");

endmodule : itc_integration_time_controller

// file: itc_cfg.svh
/*
  Constants of the integration time controller: offsets, fields, reset values, timing counts.
  Assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef ITC_CFG_SVH
`define ITC_CFG_SVH


// ==========================================================================
// Timing
`define ITC_CLK_PERIOD_NS   50
`define ITC_TICK_PERIOD_NS  1000000
`define ITC_TICK_CYCLES     ((`ITC_TICK_PERIOD_NS + `ITC_CLK_PERIOD_NS - 1) / `ITC_CLK_PERIOD_NS)

// ==========================================================================
// Shutter lines
`define ITC_FRAME_LINES     11'h420
`define ITC_NO_SHUTTER      11'h44C
`define ITC_FRACTION_LOG2   3
`define ITC_SHORT_SEL_MAX   5'h07
`define ITC_TABLE_SEL_MAX   5'h0F
`define ITC_HUNDRED_SEL_MAX 5'h17
`define ITC_HUNDRED_BASE    5'h0E
`define ITC_THOUSAND_BASE   5'h17

// ==========================================================================
// Millisecond counts
`define ITC_MS_SEL8         13'h0001
`define ITC_MS_SEL9         13'h0003
`define ITC_MS_SEL10        13'h0005
`define ITC_MS_SEL11        13'h000A
`define ITC_MS_SEL12        13'h0019
`define ITC_MS_SEL13        13'h0032
`define ITC_MS_SEL14        13'h0046
`define ITC_MS_SEL15        13'h0064
`define ITC_MS_HUNDRED      13'h0064
`define ITC_MS_THOUSAND     13'h03E8

// ==========================================================================
// Registers
`define ITC_OFS_CTRL        4'h0
`define ITC_OFS_STATUS      4'h4
`define ITC_OFS_SHUTTER     4'h8
`define ITC_OFS_MSCOUNT     4'hC
`define ITC_CTRL_DUAL_BIT   0
`define ITC_CTRL_RESET      1'b0
`define ITC_RESP_OKAY       2'h0
`define ITC_RESP_SLVERR     2'h2

`endif

// file: itc_pkg.sv
/*
  Types of the integration time controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package itc_pkg;

  typedef struct packed {
    logic [10:0] shutter_line;
    logic [12:0] ms_count;
  } itc_setting_t;

  typedef enum logic [0:0] {
    ITC_IDLE  = 1'b0,
    ITC_COUNT = 1'b1
  } itc_phase_t;

endpackage : itc_pkg

// file: itc_tg_model.sv
/*
  Behavioural timing generator on the far side of the integration time controller.
  Assumes one clock with the controller and frame lines counted as clock cycles.
*/
`timescale 1ns/1ns

module itc_tg_model #(
  parameter int LINES = 1056
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        run,
  input  wire logic        integration_done_trigger,
  input  wire logic [10:0] shutter_start_line,
  input  wire logic        shutter_line_load,
  output logic             frame_readout_done,
  output logic             shutter_start_pulse
);
  logic [10:0] line_r;
  logic [11:0] cnt_r;
  logic        reading_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) line_r <= 11'h44C;
    else if (shutter_line_load) line_r <= shutter_start_line;
  end

  // ==========================================================================
  // Frame sequencing
  always_ff @(posedge aclk) begin
    frame_readout_done  <= 1'b0;
    shutter_start_pulse <= 1'b0;
    if (!aresetn) begin
      reading_r <= 1'b1;
      cnt_r     <= 12'h000;
    end else if (run && reading_r) begin
      cnt_r <= cnt_r + 12'h001;
      if (cnt_r == {1'b0, line_r}) shutter_start_pulse <= 1'b1;
      if (cnt_r == 12'(LINES - 1)) begin
        frame_readout_done <= 1'b1;
        reading_r          <= 1'b0;
      end
    end else if (run && integration_done_trigger) begin
      reading_r <= 1'b1;
      cnt_r     <= 12'h000;
    end
  end
endmodule : itc_tg_model

// file: tb_integration_time_controller.sv
/*
  Self-checking bench of the integration time controller with a timing generator model.
  Assumes a shortened 1 ms tick of T cycles and the hand-over register map.
*/
`timescale 1ns/1ns

module tb_integration_time_controller;
  localparam int T = 8;
  logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, bin = 1'b0, run = 1'b0;
  logic [4:0]  sel = 5'h00;
  logic        done, trig, load, shut, awready, wready, bvalid, arready, rvalid;
  logic [10:0] line;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        armed = 1'b0, prev_trig = 1'b0;
  int          fails = 0, checks_done = 0, shots = 0;

  always #25 aclk = ~aclk;

  itc_integration_time_controller #(.TICK_CYCLES(T)) uut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .integration_select_bits(sel),
    .binning_select_switch(bin), .frame_readout_done(done), .integration_done_trigger(trig),
    .shutter_start_line(line), .shutter_line_load(load), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  itc_tg_model tg (
    .aclk(aclk), .aresetn(aresetn), .run(run), .integration_done_trigger(trig),
    .shutter_start_line(line), .shutter_line_load(load), .frame_readout_done(done),
    .shutter_start_pulse(shut));

  // ==========================================================================
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic timeout(input string msg);
    fails++;
    $display("wrong value at %0t: no answer, %s", $time, msg);
    end_of_test();
  endtask : timeout

  always @(posedge aclk) begin
    if (!aresetn) armed = 1'b0;
    else begin
      if (done) armed = 1'b1;
      if (shut) shots++;
      if (trig) begin
        chk({31'h0, armed & !prev_trig}, 32'h1, "single trigger");
        armed = 1'b0;
      end
    end
    prev_trig = trig;
  end

  function automatic logic [10:0] exp_line(input int s, input logic h);
    if (s == 0 || s > 7) return 11'h44C;
    return h ? 11'(66 * (8 - s)) : 11'(132 * (8 - s));
  endfunction : exp_line

  function automatic logic [12:0] exp_ms(input int s);
    int t[8] = '{1, 3, 5, 10, 25, 50, 70, 100};
    if (s < 8) return 13'h0000;
    if (s < 16) return 13'(t[s - 8]);
    if (s < 24) return 13'(100 * (s - 14));
    return 13'(1000 * (s - 23));
  endfunction : exp_ms

  // ==========================================================================
  // Bus and reset helpers
  task automatic wait_load();
    int n;
    n = 0;
    do begin @(posedge aclk); n++; end while (!load && n < 20);
    if (n >= 20) timeout("shutter load");
  endtask : wait_load

  task automatic do_reset(input logic [4:0] s, input logic b);
    @(posedge aclk);
    aresetn <= 1'b0; sel <= s; bin <= b; run <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    wait_load();
  endtask : do_reset

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st);
    int n;
    logic aw, w;
    n = 0; aw = 1'b1; w = 1'b1;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= st; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (n < 50) begin
      @(posedge aclk); n++;
      if (aw && awready) begin aw = 1'b0; awvalid <= 1'b0; end
      if (w && wready) begin w = 1'b0; wvalid <= 1'b0; end
      if (!aw && !w && bvalid) break;
    end
    if (n >= 50) timeout("write");
    chk({30'h0, bresp}, 32'h0, "bresp");
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (n < 50) begin
      @(posedge aclk); n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n >= 50) timeout("read");
    d = rdata;
    chk({30'h0, rresp}, 32'h0, "rresp");
    rready <= 1'b0;
  endtask : rd

  // ==========================================================================
  // Scenarios
  task automatic sweep();
    logic [31:0] d;
    logic [4:0]  s;
    logic        b;
    for (int k = 0; k < 40; k++) begin
      b = (k >= 32);
      s = 5'(k % 32);
      do_reset(s, b);
      chk({21'h0, line}, {21'h0, exp_line(s, b)}, "line");
      rd(4'h8, d); chk(d, {21'h0, exp_line(s, b)}, "shutter");
      rd(4'hC, d); chk({19'h0, d[12:0]}, {19'h0, exp_ms(s)}, "ms count");
      rd(4'h4, d); chk(d, {24'h0, b, 1'b0, b, s}, "status");
    end
  endtask : sweep

  task automatic trig_case(input logic [4:0] s);
    int          n, ms, base;
    logic [31:0] d;
    do_reset(s, 1'b0);
    run <= 1'b1;
    ms = int'(exp_ms(s));
    base = shots;
    for (int f = 0; f < 2; f++) begin
      n = 0;
      while (!done && n < 2000) begin @(posedge aclk); n++; end
      if (n >= 2000) timeout("readout");
      n = 0;
      do begin @(posedge aclk); n++; end while (!trig && n < T * (ms + 2) + 4);
      chk({31'h0, n > ms * T + 1 && n <= (ms + 1) * T + 1}, 32'h1, "delay");
    end
    chk(32'(shots - base), (exp_line(s, 1'b0) < 11'h420) ? 32'h2 : 32'h0,
        "shutter pulses");
    rd(4'hC, d); chk({19'h0, d[28:16]}, {19'h0, exp_ms(s)}, "counter at trigger");
    run <= 1'b0;
  endtask : trig_case

  task automatic freeze_case();
    @(posedge aclk);
    aresetn <= 1'b0; sel <= 5'h02; bin <= 1'b0; run <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    clk_en <= 1'b0;
    repeat (5) @(posedge aclk);
    chk({31'h0, load}, 32'h0, "load while frozen");
    clk_en <= 1'b1;
    wait_load();
    chk({21'h0, line}, {21'h0, exp_line(2, 1'b0)}, "line after freeze");
  endtask : freeze_case

  task automatic dual_case();
    logic [31:0] d;
    do_reset(5'h03, 1'b0);
    wr(4'h0, 32'h1, 4'hF);
    wait_load();
    chk({21'h0, line}, {21'h0, exp_line(3, 1'b1)}, "dual line");
    wr(4'h0, 32'h0, 4'h0);
    rd(4'h0, d); chk(d, 32'h1, "masked write");
    wr(4'h4, 32'hFF, 4'hF);
    rd(4'h4, d); chk(d, 32'h83, "read-only status");
  endtask : dual_case

  initial begin
    sweep();
    trig_case(5'h00);
    trig_case(5'h01);
    trig_case(5'h08);
    trig_case(5'h0B);
    trig_case(5'h0F);
    dual_case();
    freeze_case();
    end_of_test();
  end
endmodule : tb_integration_time_controller
